// ### rtl/eth_rx_descriptor_dma.sv
/*
  Receive scatter-gather DMA: fetches two-word descriptors, packs frame bytes into
  word-aligned buffers, writes per-buffer status and marks buffers used.
  Assumes a single-transfer memory port (req held until ack) in front of AHB, a byte
  stream from the MAC with FCS bytes tagged and frame results valid with rx_last,
  and APB register access on pclk.
*/
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "rxdma_defs.svh"

module eth_rx_descriptor_dma
  import rxdma_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Memory master port
  output logic             mem_req,
  output logic             mem_write,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  output logic      [3:0]  mem_be,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // Transmit side bus requests
  input  wire logic        tx_desc_req,
  input  wire logic        tx_data_req,
  output logic             tx_desc_gnt,
  output logic             tx_data_gnt,
  // Receive byte stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_fcs,
  input  wire logic        rx_last,
  output logic             rx_ready,
  // Frame results, valid with rx_last
  input  wire logic        rx_bcast,
  input  wire logic        rx_mc_hash,
  input  wire logic        rx_uc_hash,
  input  wire logic [3:0]  rx_sa_match,
  input  wire logic [3:0]  rx_tid_match,
  input  wire logic        rx_snap,
  input  wire logic [1:0]  rx_csum_chk,
  input  wire logic        rx_vlan,
  input  wire logic        rx_prio_tag,
  input  wire logic [2:0]  rx_vlan_pri,
  input  wire logic        rx_vlan_cfi,
  // Events
  output logic             buf_not_avail
);

  // ==========================================================
  // Helpers
  dma_state_t s;
  dma_state_t n;
  logic [3:0] reqs;
  logic [1:0] gnt;
  logic       gnt_any;
  logic       acc;
  logic       keep;

  // Highest-numbered match reported
  function automatic logic [1:0] hi_index(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (m[i]) begin
        r = i[1:0];
      end
    end
    return r;
  endfunction : hi_index

  // Buffer size in bytes, field in 64-byte units, zero means 16 Kbytes
  function automatic logic [14:0] buf_bytes(input logic [31:0] d);
    logic [7:0] f;
    f = d[`DCFG_BSZ_HI:`DCFG_BSZ_LO];
    return (f == 8'h00) ? 15'h4000 : {1'b0, f, 6'h00};
  endfunction : buf_bytes

  // ==========================================================
  // Bus requests to the arbiter
  always_comb begin
    reqs[`REQ_RX_DESC] = (s.st == S_FETCH) || (s.st == S_STAT) || (s.st == S_USED);
    reqs[`REQ_TX_DESC] = tx_desc_req;
    reqs[`REQ_RX_DATA] = (s.st == S_FILL) && s.pend;
    reqs[`REQ_TX_DATA] = tx_data_req;
  end

  req_arbiter u_arb (
    .req (reqs),
    .gnt (gnt),
    .any (gnt_any)
  );

  assign acc  = s.rx_ready && rx_valid;
  assign keep = !(rx_fcs && s.ncfg[`NCFG_FCS_STRIP]);

  // ==========================================================
  // Next state
  always_comb begin
    n           = s;
    n.bna_pulse = 1'b0;

    // APB setup: answer next cycle
    if (psel && !penable && !s.pready) begin
      n.pready  = 1'b1;
      n.pslverr = 1'b0;
      case (paddr[7:0])
        `OFS_NET_CFG:   n.prdata = s.ncfg;
        `OFS_DMA_CFG:   n.prdata = s.dcfg;
        `OFS_RXQ_BASE:  n.prdata = s.qptr;
        `OFS_NET_CTRL:  n.prdata = {29'h0, s.rx_en, 2'h0};
        `OFS_RX_STATUS: n.prdata = {30'h0, s.bna, 1'b0};
        `OFS_RES_ERR:   n.prdata = {16'h0, s.rerr};
        default: begin
          n.prdata  = 32'h0000_0000;
          n.pslverr = 1'b1;
        end
      endcase
    end

    // APB access completes
    if (psel && penable && s.pready) begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      if (pwrite) begin
        case (paddr[7:0])
          `OFS_NET_CFG: n.ncfg = pwdata;
          `OFS_DMA_CFG: n.dcfg = pwdata;
          `OFS_RXQ_BASE: begin
            if (!s.rx_en) begin
              n.base = {pwdata[31:2], 2'h0};
              n.qptr = {pwdata[31:2], 2'h0};
            end
          end
          `OFS_NET_CTRL: n.rx_en = pwdata[`CTRL_RX_EN];
          `OFS_RX_STATUS: begin
            if (pwdata[`RSTAT_BNA]) begin
              n.bna = 1'b0;
            end
          end
          default: n.rx_en = s.rx_en;
        endcase
      end
    end

    // Lent transmit grants end when the request drops
    if (s.tx_desc_gnt && !tx_desc_req) begin
      n.tx_desc_gnt = 1'b0;
    end
    if (s.tx_data_gnt && !tx_data_req) begin
      n.tx_data_gnt = 1'b0;
    end

    // Arbitrate when the bus is free
    if (!s.mem_req && !s.tx_desc_gnt && !s.tx_data_gnt && gnt_any) begin
      case (gnt)
        `REQ_RX_DESC: begin
          n.mem_req = 1'b1;
          n.mem_be  = 4'hF;
          case (s.st)
            S_FETCH: begin
              n.mem_write = 1'b0;
              n.mem_addr  = s.qptr;
            end
            S_STAT: begin
              n.mem_write = 1'b1;
              n.mem_addr  = s.qptr + `DESC_STAT_OFS;
              if (s.done) begin
                n.mem_wdata = {s.stat, 1'b1, s.sof, 1'b0, s.flen};
              end else begin
                n.mem_wdata = s.sof ? `STAT_SOF : 32'h0000_0000;
              end
            end
            default: begin
              n.mem_write = 1'b1;
              n.mem_addr  = s.qptr;
              n.mem_wdata = {s.bufw, s.wrap, 1'b1};
            end
          endcase
        end
        `REQ_TX_DESC: n.tx_desc_gnt = 1'b1;
        `REQ_RX_DATA: begin
          n.mem_req   = 1'b1;
          n.mem_write = 1'b1;
          n.mem_addr  = {s.waddr, 2'h0};
          n.mem_wdata = s.wbuf;
          n.mem_be    = s.be;
        end
        default: n.tx_data_gnt = 1'b1;
      endcase
    end

    // Engine
    case (s.st)
      S_IDLE: begin
        if (s.drop && acc && rx_last) begin
          n.drop = 1'b0;
        end else if (!s.drop && s.rx_en && rx_valid) begin
          n.st   = S_FETCH;
          n.sof  = 1'b1;
          n.flen = 13'h0000;
          n.done = 1'b0;
        end
      end
      S_FETCH: begin
        if (s.mem_req && mem_ack) begin
          n.mem_req = 1'b0;
          if (mem_rdata[`DESC_OWN]) begin
            n.bna       = 1'b1;
            n.bna_pulse = 1'b1;
            n.rerr      = s.rerr + 16'h0001;
            n.drop      = 1'b1;
            n.st        = S_IDLE;
          end else begin
            n.bufw  = mem_rdata[31:2];
            n.waddr = mem_rdata[31:2];
            n.wrap  = mem_rdata[`DESC_WRAP];
            n.be    = 4'h0;
            n.wbuf  = 32'h0000_0000;
            n.st    = S_FILL;
            if (s.sof) begin
              n.lane = s.ncfg[`NCFG_OFS_HI:`NCFG_OFS_LO];
              n.room = buf_bytes(s.dcfg) - {13'h0000, s.ncfg[`NCFG_OFS_HI:`NCFG_OFS_LO]};
            end else begin
              n.lane = 2'h0;
              n.room = buf_bytes(s.dcfg);
            end
          end
        end
      end
      S_FILL: begin
        // Finished word written
        if (s.mem_req && mem_ack) begin
          n.mem_req = 1'b0;
          n.pend    = 1'b0;
          n.be      = 4'h0;
          n.wbuf    = 32'h0000_0000;
          n.waddr   = s.waddr + 30'h0000_0001;
        end
        // Pack accepted byte
        if (acc) begin
          if (keep) begin
            n.wbuf[{s.lane, 3'b000} +: 8] = rx_byte;
            n.be[s.lane] = 1'b1;
            n.lane = s.lane + 2'h1;
            n.room = s.room - 15'h0001;
            n.flen = s.flen + 13'h0001;
            if ((s.lane == 2'h3) || (s.room == 15'h0001)) begin
              n.pend = 1'b1;
            end
          end
          if (rx_last) begin
            n.done = 1'b1;
            n.stat = {rx_bcast, rx_mc_hash, rx_uc_hash, 1'b0,
                      |rx_sa_match, hi_index(rx_sa_match),
                      s.ncfg[`NCFG_CSUM_EN] ? (rx_snap && (!rx_vlan || !rx_vlan_cfi)) : |rx_tid_match,
                      s.ncfg[`NCFG_CSUM_EN] ? rx_csum_chk : hi_index(rx_tid_match),
                      rx_vlan, rx_prio_tag, rx_vlan_pri, rx_vlan_cfi};
            if (n.be != 4'h0) begin
              n.pend = 1'b1;
            end
          end
        end
        // Buffer full or frame over with nothing left to write
        if (!n.pend && (n.done || (n.room == 15'h0000))) begin
          n.st = S_STAT;
        end
      end
      S_STAT: begin
        if (s.mem_req && mem_ack) begin
          n.mem_req = 1'b0;
          n.st      = S_USED;
        end
      end
      S_USED: begin
        if (s.mem_req && mem_ack) begin
          n.mem_req = 1'b0;
          n.qptr    = s.wrap ? s.base : s.qptr + `DESC_STEP;
          n.sof     = 1'b0;
          n.st      = s.done ? S_IDLE : S_FETCH;
        end
      end
      default: n.st = S_IDLE;
    endcase

    // Registered stream ready
    n.rx_ready = ((n.st == S_FILL) && !n.pend && !n.done && (n.room != 15'h0000)) ||
                 ((n.st == S_IDLE) && n.drop);
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s      <= '0;
      s.st   <= S_IDLE;
      s.ncfg <= `NET_CFG_RST;
      s.dcfg <= `DMA_CFG_RST;
      s.base <= `RXQ_BASE_RST;
      s.qptr <= `RXQ_BASE_RST;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // Outputs straight from the state record
  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign mem_req       = s.mem_req;
  assign mem_write     = s.mem_write;
  assign mem_addr      = s.mem_addr;
  assign mem_wdata     = s.mem_wdata;
  assign mem_be        = s.mem_be;
  assign tx_desc_gnt   = s.tx_desc_gnt;
  assign tx_data_gnt   = s.tx_data_gnt;
  assign rx_ready      = s.rx_ready;
  assign buf_not_avail = s.bna_pulse;

endmodule : eth_rx_descriptor_dma

`default_nettype wire

// ### rtl/rxdma_defs.svh
/*
  Offsets, field positions, reset values and encodings of the receive descriptor DMA.
  Assumes byte addressing on APB with one aligned 32-bit word per register.
*/
`ifndef RXDMA_DEFS_SVH
`define RXDMA_DEFS_SVH

// ==========================================================
// Register offsets
`define OFS_NET_CFG      8'h00
`define OFS_DMA_CFG      8'h04
`define OFS_RXQ_BASE     8'h08
`define OFS_NET_CTRL     8'h0C
`define OFS_RX_STATUS    8'h10
`define OFS_RES_ERR      8'h14

// ==========================================================
// Field positions
`define NCFG_OFS_LO      14
`define NCFG_OFS_HI      15
`define NCFG_FCS_STRIP   17
`define NCFG_CSUM_EN     24
`define DCFG_BSZ_LO      16
`define DCFG_BSZ_HI      23
`define CTRL_RX_EN       2
`define RSTAT_BNA        1

// ==========================================================
// Reset values
`define NET_CFG_RST      32'h0000_0000
`define DMA_CFG_RST      32'h0002_0000
`define RXQ_BASE_RST     32'h0000_0000

// ==========================================================
// Descriptor layout
`define DESC_OWN         0
`define DESC_WRAP        1
`define DESC_STAT_OFS    32'h0000_0004
`define DESC_STEP        32'h0000_0008
`define STAT_SOF         32'h0000_4000

// ==========================================================
// Bus requester indices, highest priority first
`define REQ_RX_DESC      2'h0
`define REQ_TX_DESC      2'h1
`define REQ_RX_DATA      2'h2
`define REQ_TX_DATA      2'h3

`endif

// ### rtl/rxdma_pkg.sv
/*
  Types of the receive descriptor DMA: engine states and the packed state record.
  Assumes rxdma_defs.svh for all numeric constants.
*/
package rxdma_pkg;

  // ==========================================================
  // Engine states, Gray along idle-fetch-fill-status-used
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FETCH = 3'b001,
    S_FILL  = 3'b011,
    S_STAT  = 3'b010,
    S_USED  = 3'b110
  } rx_state_t;

  // ==========================================================
  // Whole state of the engine
  typedef struct packed {
    rx_state_t   st;
    logic [31:0] ncfg;
    logic [31:0] dcfg;
    logic [31:0] base;
    logic [31:0] qptr;
    logic        rx_en;
    logic        bna;
    logic [15:0] rerr;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mem_req;
    logic        mem_write;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [3:0]  mem_be;
    logic        tx_desc_gnt;
    logic        tx_data_gnt;
    logic [29:0] bufw;
    logic        wrap;
    logic [29:0] waddr;
    logic [31:0] wbuf;
    logic [3:0]  be;
    logic [1:0]  lane;
    logic [14:0] room;
    logic [12:0] flen;
    logic        pend;
    logic        done;
    logic        sof;
    logic [15:0] stat;
    logic        drop;
    logic        rx_ready;
    logic        bna_pulse;
  } dma_state_t;

endpackage : rxdma_pkg

// ### rtl/req_arbiter.sv
/*
  Fixed-priority arbiter for the shared memory bus; index 0 wins.
  Assumes requests are sampled only while the bus is free.
*/
`timescale 1ns/1ns
`default_nettype none

module req_arbiter (
  // Requests, bit 0 highest priority
  input  wire logic [3:0] req,
  // Winner
  output logic [1:0]      gnt,
  output logic            any
);

  // ==========================================================
  // Priority encode from the top requester down
  always_comb begin
    any = |req;
    gnt = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) begin
        gnt = i[1:0];
      end
    end
  end

endmodule : req_arbiter

`default_nettype wire

// ### bench/rxdma_assertions.sv
/*
  Checker of the receive DMA memory port, bus lending and used-buffer events.
  Assumes the top module's port names; bound at the foot of this file.
*/
`timescale 1ns/1ns
`default_nettype none
module rxdma_assertions (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Memory port
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0]  mem_be,
  input wire logic        mem_ack,
  input wire logic [31:0] mem_rdata,
  // Bus lending and events
  input wire logic        tx_desc_req,
  input wire logic        tx_data_req,
  input wire logic        tx_desc_gnt,
  input wire logic        tx_data_gnt,
  input wire logic        buf_not_avail
);
  // ==========
  // Clocking, and a finished read (only descriptors are read)
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_done = mem_req && !mem_write && mem_ack;

  // ==========
  // Properties
  a_lend_quiet: assert property ((tx_desc_gnt || tx_data_gnt) |-> !mem_req)
    else $error("memory request while bus lent");
  a_desc_first: assert property (tx_desc_req && tx_data_req && !tx_desc_gnt && !tx_data_gnt |=> !tx_data_gnt)
    else $error("data grant beat descriptor grant");
  a_read_word: assert property (mem_req && !mem_write |-> mem_addr[1:0] == 2'h0 && mem_be == 4'hF)
    else $error("descriptor read not a whole word");
  a_used_skip: assert property (rd_done && mem_rdata[0] |=> !(mem_req && mem_write) [*8])
    else $error("write after used descriptor");
  a_used_flag: assert property (rd_done && mem_rdata[0] |-> ##[1:4] buf_not_avail)
    else $error("no event for used descriptor");
  a_free_quiet: assert property (rd_done && !mem_rdata[0] |=> !buf_not_avail [*4])
    else $error("event for free descriptor");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata)
    && $stable(mem_write) && $stable(mem_be)) else $error("memory request changed before ack");
  a_req_gap: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("request not released after ack");
endmodule : rxdma_assertions

bind eth_rx_descriptor_dma rxdma_assertions u_rxdma_assertions (
  .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
  .tx_desc_req(tx_desc_req), .tx_data_req(tx_data_req), .tx_desc_gnt(tx_desc_gnt),
  .tx_data_gnt(tx_data_gnt), .buf_not_avail(buf_not_avail));
`default_nettype wire

// ### bench/rxdma_mem_model.sv
/*
  Word memory answering the DMA memory port after lag extra cycles.
  Assumes req held until ack; the bench reaches the array directly.
*/
`timescale 1ns/1ns
`default_nettype none
module rxdma_mem_model (
  // Clock
  input  wire logic        clk,
  // Request
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  be,
  input  wire logic [1:0]  lag,
  // Answer
  output logic             ack,
  output logic      [31:0] rdata
);
  logic [31:0] mem [0:1023];
  logic [1:0]  cnt = 2'h0;
  int          b;
  initial ack = 1'b0;
  initial rdata = 32'h0;

  // Answer once lag is used up; read data toggles in every cycle but the ack cycle of a read
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (req && !ack) begin
      if (cnt != lag) begin
        cnt <= cnt + 2'h1;
      end else begin
        cnt <= 2'h0;
        ack <= 1'b1;
        if (!we) begin
          rdata <= mem[addr[11:2]];
        end else begin
          for (b = 0; b < 4; b++) begin
            if (be[b]) mem[addr[11:2]][8*b +: 8] <= wdata[8*b +: 8];
          end
        end
      end
    end
  end
endmodule : rxdma_mem_model
`default_nettype wire

// ### bench/tb_top.sv
/*
  Self-checking bench of the receive DMA: APB tasks, byte-stream frames, and
  descriptors and buffers read back from the memory model.
  Assumes the memory model on the memory port and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rxdma_defs.svh"
module tb_top;
  // ==========
  // Stimulus and observed signals
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic        pready, pslverr, mem_req, mem_write, mem_ack, err, bna, desc_gnt, data_gnt, rx_ready;
  logic        desc_req = 1'b0, data_req = 1'b0, rx_valid = 1'b0, rx_fcs = 1'b0, rx_last = 1'b0;
  logic        bcast = 1'b0, mc = 1'b0, uc = 1'b0, snap = 1'b0, vlan = 1'b0, prio = 1'b0, cfi = 1'b0;
  logic [2:0]  pri = 3'h0;
  logic [7:0]  rx_byte = 8'h0;
  logic [3:0]  mem_be, sa = 4'h0, tid = 4'h0;
  logic [1:0]  csum = 2'h0, lag = 2'h0;
  int          error_cnt = 0, cmp_count = 0;

  eth_rx_descriptor_dma u_eth_rx_descriptor_dma (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_be(mem_be), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .tx_desc_req(desc_req),
    .tx_data_req(data_req), .tx_desc_gnt(desc_gnt), .tx_data_gnt(data_gnt),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_fcs(rx_fcs), .rx_last(rx_last),
    .rx_ready(rx_ready), .rx_bcast(bcast), .rx_mc_hash(mc), .rx_uc_hash(uc),
    .rx_sa_match(sa), .rx_tid_match(tid), .rx_snap(snap), .rx_csum_chk(csum), .rx_vlan(vlan),
    .rx_prio_tag(prio), .rx_vlan_pri(pri), .rx_vlan_cfi(cfi), .buf_not_avail(bna));
  rxdma_mem_model u_mem (
    .clk(pclk), .req(mem_req), .we(mem_write), .addr(mem_addr), .wdata(mem_wdata),
    .be(mem_be), .lag(lag), .ack(mem_ack), .rdata(mem_rdata));

  // 100 MHz clock
  always #5 pclk = ~pclk;

  // ==========
  // Report, compare and bus tasks
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic hang(input string what);
    chk(what, 32'h1, 32'h0);
    summarize();
  endtask : hang
  // Setup then access phase, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) hang("apb ready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdc
  task automatic gnt(input logic [1:0] want);
    int n;
    for (n = 0; n < 20 && {desc_gnt, data_gnt} !== want; n++) @(posedge pclk);
    if ({desc_gnt, data_gnt} !== want) hang("grant");
  endtask : gnt
  // One frame of byte values 0, 1, 2 ..., the last nfcs tagged as FCS
  task automatic send(input int len, input int nfcs);
    int i;
    int n;
    @(posedge pclk);
    for (i = 0; i < len; i++) begin
      rx_valid <= 1'b1;
      rx_byte <= i[7:0];
      rx_fcs <= (i >= len - nfcs);
      rx_last <= (i == len - 1);
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (rx_ready !== 1'b1 && n < 500);
      if (rx_ready !== 1'b1) hang("stream");
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask : send
  task automatic wait_used(input int i);
    int n;
    for (n = 0; n < 3000 && u_mem.mem[i][0] !== 1'b1; n++) @(posedge pclk);
    if (u_mem.mem[i][0] !== 1'b1) hang("used bit");
  endtask : wait_used

  // ==========
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`OFS_DMA_CFG, `DMA_CFG_RST, "dma cfg reset");
    rdc(`OFS_NET_CFG, `NET_CFG_RST, "net cfg reset");
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    // Both transmit requesters at once, descriptor side first
    desc_req <= 1'b1;
    data_req <= 1'b1;
    gnt(2'b10);
    desc_req <= 1'b0;
    gnt(2'b01);
    data_req <= 1'b0;
    // Two free descriptors at 0x100, the second wraps; own bit clear, so the DMA may use them
    u_mem.mem[10'h40] = 32'h0000_0200;
    u_mem.mem[10'h42] = 32'h0000_0302;
    apb(1'b1, `OFS_RXQ_BASE, 32'h0000_0100);
    apb(1'b1, `OFS_DMA_CFG, 32'h0001_0000);
    apb(1'b1, `OFS_NET_CTRL, 32'h0000_0004);
    rdc(`OFS_RXQ_BASE, 32'h0000_0100, "queue pointer");
    apb(1'b1, `OFS_RXQ_BASE, 32'h0000_0500);
    rdc(`OFS_RXQ_BASE, 32'h0000_0100, "locked base");
    // Frame of 70 bytes over two 64-byte buffers
    bcast <= 1'b1;
    sa <= 4'h6;
    tid <= 4'h9;
    vlan <= 1'b1;
    {prio, pri, cfi} <= 5'h1B;
    send(70, 4);
    wait_used(32'h42);
    chk("desc0 word0", 32'h0000_0201, u_mem.mem[10'h40]);
    chk("desc0 status", `STAT_SOF, u_mem.mem[10'h41]);
    chk("desc1 word0", 32'h0000_0303, u_mem.mem[10'h42]);
    chk("desc1 status", 32'h8DFB_8046, u_mem.mem[10'h43]);
    chk("buffer0 word0", 32'h0302_0100, u_mem.mem[10'h80]);
    chk("buffer1 tail", 32'h0000_4544, {16'h0, u_mem.mem[10'hC1][15:0]});
    // Pointer wrapped onto a used descriptor: frame dropped
    send(10, 0);
    rdc(`OFS_RX_STATUS, 32'h0000_0002, "not available");
    rdc(`OFS_RES_ERR, 32'h0000_0001, "resource errors");
    rdc(`OFS_RXQ_BASE, 32'h0000_0100, "wrapped pointer");
    chk("buffer0 kept", 32'h0302_0100, u_mem.mem[10'h80]);
    apb(1'b1, `OFS_RX_STATUS, 32'h0000_0002);
    rdc(`OFS_RX_STATUS, 32'h0000_0000, "status cleared");
    // Recycled buffers, offset 2, FCS strip, offload on, slow memory
    u_mem.mem[10'h40] = 32'h0000_0200;
    u_mem.mem[10'h42] = 32'h0000_0302;
    apb(1'b1, `OFS_NET_CFG, 32'h0102_8000);
    // Untagged frame with the CFI input still set: offload flag must not look at CFI
    {bcast, sa, tid, mc, uc, snap, csum, lag, vlan} <= {1'b0, 8'h00, 3'h7, 2'h2, 2'h3, 1'b0};
    send(67, 4);
    wait_used(32'h42);
    chk("offset first word", 32'h0100_0100, u_mem.mem[10'h80]);
    chk("desc0 status", `STAT_SOF, u_mem.mem[10'h41]);
    chk("second buffer word", 32'h4342_413E, u_mem.mem[10'hC0]);
    chk("desc1 status", 32'h619B_803F, u_mem.mem[10'h43]);
    rdc(`OFS_RXQ_BASE, 32'h0000_0100, "pointer at base");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
